// File: design/acs_defs.vh
// Constants for the converter channel sequencer serial port.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_FRAME_BITS      5'd16
`define ACS_CNT_W           5
`define ACS_RESULT_W        12
`define ACS_TAG_W           4
`define ACS_WORD_W          16
`define ACS_NUM_SRC         9
`define ACS_TEMP_TAG        4'h8
`define ACS_WR_BIT          15
`define ACS_TSEL_BIT        14
`define ACS_STBY_BIT        13
`define ACS_CHMASK_MSB      7
`define ACS_CLK_MHZ         20
`define ACS_TEMP_CONV_US    100
`define ACS_TEMP_CONV_CYC   (`ACS_TEMP_CONV_US * `ACS_CLK_MHZ)
`define ACS_TEMP_CNT_W      12
`define ACS_FIFO_DEPTH      16
`define ACS_FIFO_AW         4
`define ACS_IDLE_WORD       16'hffff
`endif

// File: design/acs_fifo.v
// Small synchronous FIFO that buffers converted result words.
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             i_clk_sys,
   input  wire             i_resetn,
   input  wire             i_flush,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output reg  [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_q;
   reg [AW:0]      rd_q;
   reg             oval_q;
   wire [AW:0]     count;
   wire [AW+1:0]   fill;
   wire            do_wr;
   wire            do_rd;

   assign count       = wr_q - rd_q;
   // The output register counts as one of the DEPTH places, so the
   // buffer refuses a word once DEPTH words are held in total.
   assign fill        = {1'b0, count} + {{(AW+1){1'b0}}, oval_q};
   assign o_in_ready  = (fill != DEPTH[AW+1:0]);
   assign o_out_valid = oval_q;
   assign do_wr       = i_in_valid & o_in_ready;
   // The output register is refilled whenever it is empty or being taken.
   assign do_rd       = (count != {(AW+1){1'b0}}) & (~oval_q | i_out_ready);

   always @(posedge i_clk_sys) begin
      if (do_wr) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_q       <= {(AW+1){1'b0}};
         rd_q       <= {(AW+1){1'b0}};
         oval_q     <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end else if (i_flush) begin
         wr_q   <= {(AW+1){1'b0}};
         rd_q   <= {(AW+1){1'b0}};
         oval_q <= 1'b0;
      end else begin
         if (do_wr) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_rd) begin
            rd_q       <= rd_q + 1'b1;
            o_out_data <= mem[rd_q[AW-1:0]];
            oval_q     <= 1'b1;
         end else if (i_out_ready) begin
            oval_q <= 1'b0;
         end
      end
   end
endmodule

// File: design/acs_port.v
// Serial control port and channel sequencer of a 12-bit eight-input converter.
//
// What this block does
// - Active-low select frames every transfer.
// - One low pin means power-down or reset.
// - Temperature busy high until conversion ends.
// - Temperature-select bit set selects the sensor.
// - Result is shifted out one frame later.
// - After power-up no channel, output all ones.
// - Nine-way source choice per frame.
// - Selected channels scanned in fixed order, repeating.
// - Hardware power-down and software standby states.
// - Each result is twelve bits.
// - Temperature step is a quarter degree.
// - Output word is channel tag then result.
// - Early deselect aborts, floats output, keeps control.
// - Input captured on falling edges; write flag gates.
`timescale 1ns/10ps
`include "acs_defs.vh"
module acs_port (
   input  wire        i_clk_sys,
   input  wire        i_resetn,
   input  wire        i_power_down_reset_n,
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_din,
   output reg         o_serial_out_line,
   output reg         o_serial_out_oe,
   output reg         o_temp_conv_busy,
   output wire        o_hw_power_down,
   output wire        o_standby,
   output reg  [3:0]  o_mux_sel,
   output reg         o_mux_valid,
   output reg         o_sample,
   input  wire [11:0] i_conv_result,
   output wire        o_buf_valid,
   input  wire        i_buf_ready,
   output wire [15:0] o_buf_word,
   output wire        o_buf_in_ready
);
   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   reg [1:0] cs_s_q;
   reg [1:0] sclk_s_q;
   reg [1:0] din_s_q;
   reg [1:0] pdr_s_q;
   reg       sclk_prev_q;
   reg       cs_prev_q;

   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         // Reset values match the idle pin levels, so neither a false clock
         // edge nor a false power-down report follows the release of reset.
         cs_s_q      <= 2'h3;
         sclk_s_q    <= 2'h0;
         din_s_q     <= 2'h0;
         pdr_s_q     <= 2'h3;
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         cs_s_q      <= {cs_s_q[0], i_cs_n};
         sclk_s_q    <= {sclk_s_q[0], i_sclk};
         din_s_q     <= {din_s_q[0], i_din};
         pdr_s_q     <= {pdr_s_q[0], i_power_down_reset_n};
         sclk_prev_q <= sclk_s_q[1];
         cs_prev_q   <= cs_s_q[1];
      end
   end

   // ****************************************************************
   // Edge detection
   // ****************************************************************
   wire cs_n     = cs_s_q[1];
   wire sclk_fall = sclk_prev_q & ~sclk_s_q[1];
   wire cs_fall  = cs_prev_q & ~cs_n;
   wire cs_rise  = ~cs_prev_q & cs_n;
   wire pd_low   = ~pdr_s_q[1];
   // The host clock runs at most half as fast as ours, so a 20 MHz link needs
   // a faster system clock in silicon; the bench link is far slower.

   // ****************************************************************
   // Control state and sequencer
   // ****************************************************************
   reg [7:0]  chmask_q;
   reg        tsel_q;
   reg        stby_q;
   reg        progd_q;
   reg [3:0]  next_q;
   reg [4:0]  bitcnt_q;
   reg        active_q;
   reg [15:0] din_sr_q;
   reg [15:0] dout_sr_q;
   reg [15:0] pend_q;
   reg        pend_valid_q;
   reg [11:0] tcnt_q;

   // Last count of the sensor conversion timer.
   localparam [`ACS_TEMP_CNT_W-1:0] TEMP_LAST = `ACS_TEMP_CONV_CYC - 1;

   // ****************************************************************
   // Source selection helpers
   // ****************************************************************
   // True when at least one of the nine sources is enabled.
   function has_source;
      input [7:0] mask;
      input       tsel;
      begin
         has_source = (mask != 8'h00) | tsel;
      end
   endfunction

   // True when source idx is enabled; codes above the sensor never are.
   function src_on;
      input [3:0] idx;
      input [7:0] mask;
      input       tsel;
      reg   [8:0] sel;
      begin
         sel    = {tsel, mask};
         src_on = (idx <= `ACS_TEMP_TAG) ? sel[idx] : 1'b0;
      end
   endfunction

   // Next source after cur in fixed order 0..7 then sensor, wrapping.
   function [3:0] next_src;
      input [3:0] cur;
      input [7:0] mask;
      input       tsel;
      reg   [3:0] res;
      reg         found;
      integer     k;
      integer     idx;
      begin
         res   = cur;
         found = 1'b0;
         for (k = 1; k <= `ACS_NUM_SRC; k = k + 1) begin
            idx = (cur + k) % `ACS_NUM_SRC;
            if (!found && src_on(idx[3:0], mask, tsel)) begin
               res   = idx[3:0];
               found = 1'b1;
            end
         end
         next_src = res;
      end
   endfunction

   wire any_sel   = has_source(chmask_q, tsel_q);
   wire [15:0] wr_word = {din_sr_q[14:0], din_s_q[1]};
   wire last_edge = active_q & sclk_fall & (bitcnt_q == `ACS_FRAME_BITS - 5'd1);
   wire fifo_in_ready;
   // While the sensor timer runs, or in standby, a frame still shifts but
   // yields no new result, so the host reads the previous word again.
   wire conv_done = last_edge & progd_q & ~stby_q & ~o_temp_conv_busy;

   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         chmask_q          <= 8'h00;
         tsel_q            <= 1'b0;
         stby_q            <= 1'b0;
         progd_q           <= 1'b0;
         next_q            <= 4'h0;
         bitcnt_q          <= 5'd0;
         active_q          <= 1'b0;
         din_sr_q          <= 16'h0000;
         dout_sr_q         <= `ACS_IDLE_WORD;
         pend_q            <= `ACS_IDLE_WORD;
         pend_valid_q      <= 1'b0;
         o_serial_out_line <= 1'b1;
         o_serial_out_oe   <= 1'b0;
         o_mux_sel         <= 4'h0;
         o_mux_valid       <= 1'b0;
         o_sample          <= 1'b0;
         o_temp_conv_busy  <= 1'b0;
         tcnt_q            <= 12'h000;
      end else if (pd_low) begin
         // Power-down/reset pin low: all but o_mux_sel and din_sr_q back to power-up state.
         chmask_q          <= 8'h00;
         tsel_q            <= 1'b0;
         stby_q            <= 1'b0;
         progd_q           <= 1'b0;
         next_q            <= 4'h0;
         bitcnt_q          <= 5'd0;
         active_q          <= 1'b0;
         dout_sr_q         <= `ACS_IDLE_WORD;
         pend_q            <= `ACS_IDLE_WORD;
         pend_valid_q      <= 1'b0;
         o_serial_out_line <= 1'b1;
         o_serial_out_oe   <= 1'b0;
         o_mux_valid       <= 1'b0;
         o_sample          <= 1'b0;
         o_temp_conv_busy  <= 1'b0;
         tcnt_q            <= 12'h000;
      end else begin
         o_sample <= 1'b0;
         // Temperature conversion timer.
         if (o_temp_conv_busy) begin
            if (tcnt_q == TEMP_LAST) begin
               o_temp_conv_busy <= 1'b0;
               tcnt_q           <= 12'h000;
            end else begin
               tcnt_q <= tcnt_q + 12'h001;
            end
         end
         if (cs_fall) begin
            // Frame opens: drive the tag MSB of last frame's result.
            active_q          <= 1'b1;
            bitcnt_q          <= 5'd0;
            dout_sr_q         <= {pend_q[14:0], 1'b1};
            o_serial_out_line <= pend_q[15];
            o_serial_out_oe   <= 1'b1;
         end else if (cs_rise && active_q) begin
            // Early deselect: abort, float output, control untouched.
            // The line goes back to ones, as between frames.
            active_q          <= 1'b0;
            o_serial_out_oe   <= 1'b0;
            o_serial_out_line <= 1'b1;
         end else if (active_q && sclk_fall) begin
            din_sr_q <= wr_word;
            bitcnt_q <= bitcnt_q + 5'd1;
            o_serial_out_line <= dout_sr_q[15];
            dout_sr_q <= {dout_sr_q[14:0], 1'b1};
            if (last_edge) begin
               active_q        <= 1'b0;
               o_serial_out_oe <= 1'b0;
               if (conv_done) begin
                  // Tag plus twelve-bit result, read next frame.
                  pend_q       <= {o_mux_sel, i_conv_result};
                  pend_valid_q <= 1'b1;
                  o_sample     <= 1'b1;
                  if (o_mux_sel == `ACS_TEMP_TAG) begin
                     // Sensor LSB weight is a quarter degree, no scaling.
                     o_temp_conv_busy <= 1'b1;
                     tcnt_q           <= 12'h000;
                  end
               end else begin
                  pend_valid_q <= 1'b0;
               end
               if (wr_word[`ACS_WR_BIT]) begin
                  // Only a flagged write changes control state.
                  chmask_q <= wr_word[`ACS_CHMASK_MSB:0];
                  tsel_q   <= wr_word[`ACS_TSEL_BIT];
                  stby_q   <= wr_word[`ACS_STBY_BIT];
                  progd_q  <= has_source(wr_word[`ACS_CHMASK_MSB:0],
                                         wr_word[`ACS_TSEL_BIT]);
                  next_q   <= 4'h0;
               end else if (any_sel) begin
                  next_q <= next_src(o_mux_sel, chmask_q, tsel_q);
               end
            end
         end else begin
            pend_valid_q <= 1'b0;
         end
         if (!active_q) begin
            // Choose this frame's source among the nine.
            if (!has_source(chmask_q, tsel_q)) begin
               o_mux_valid <= 1'b0;
               if (!progd_q) begin
                  pend_q <= `ACS_IDLE_WORD;
               end
            end else begin
               o_mux_valid <= 1'b1;
               if (src_on(next_q, chmask_q, tsel_q)) begin
                  o_mux_sel <= next_q;
               end else begin
                  o_mux_sel <= next_src(next_q, chmask_q, tsel_q);
               end
            end
         end
      end
   end

   // ****************************************************************
   // Low-power status
   // ****************************************************************
   assign o_hw_power_down = pd_low;
   assign o_standby       = stby_q;

   // ****************************************************************
   // Result buffer
   // ****************************************************************
   // Words are offered to a local consumer; if it stalls and the buffer
   // fills, further results are dropped but the serial path is unaffected.
   acs_fifo #(
      .WIDTH (`ACS_WORD_W),
      .DEPTH (`ACS_FIFO_DEPTH),
      .AW    (`ACS_FIFO_AW)
   ) u_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_resetn    (i_resetn),
      .i_flush     (pd_low),
      .i_in_valid  (pend_valid_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (pend_q),
      .o_out_valid (o_buf_valid),
      .i_out_ready (i_buf_ready),
      .o_out_data  (o_buf_word)
   );
   assign o_buf_in_ready = fifo_in_ready;
endmodule

// File: dv/acs_host_model.sv
// Serial host model that frames transfers towards the converter port.
`timescale 1ns/10ps
module acs_host_model (
   input  wire logic i_clk_sys,
   input  wire logic i_line,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_din
);
   // The serial clock stands low between frames, so no edge is ever seen outside one.
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din  = 1'b0;
   end
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
      int i;
      r = 16'h0;
      @(posedge i_clk_sys) o_cs_n <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
      for (i = 0; i < n; i++) begin
         o_sclk <= 1'b1;
         o_din  <= w[15-i];
         repeat (4) @(posedge i_clk_sys);
         r = {r[14:0], i_line};
         o_sclk <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
      end
      o_cs_n <= 1'b1;
      // A released data line must not keep showing the last bit.
      o_din  <= ~o_din;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule

// File: dv/acs_port_monitor.sv
// Concurrent checks on the converter serial port outputs.
`timescale 1ns/10ps
module acs_port_monitor (
   input wire logic        i_clk_sys,
   input wire logic        i_resetn,
   input wire logic        i_power_down_reset_n,
   input wire logic        i_cs_n,
   input wire logic        o_serial_out_line,
   input wire logic        o_serial_out_oe,
   input wire logic        o_temp_conv_busy,
   input wire logic        o_hw_power_down,
   input wire logic [3:0]  o_mux_sel,
   input wire logic        o_mux_valid,
   input wire logic        o_sample,
   input wire logic        o_buf_valid,
   input wire logic        i_buf_ready,
   input wire logic [15:0] o_buf_word
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   logic [11:0] busy_cnt_q;
   always @(posedge i_clk_sys or negedge i_resetn)
      if (!i_resetn) busy_cnt_q <= 12'h0;
      else busy_cnt_q <= o_temp_conv_busy ? busy_cnt_q + 12'h1 : 12'h0;
   a_idle_ones: assert property (!o_serial_out_oe |-> o_serial_out_line)
      else $error("serial line not high while idle");
   a_cs_opens: assert property (
      $fell(i_cs_n) && i_power_down_reset_n |-> ##[1:5] o_serial_out_oe)
      else $error("output not enabled after select");
   a_cs_quiet: assert property (i_cs_n [*5] |-> !o_serial_out_oe)
      else $error("output driven without select");
   a_busy_bound: assert property (busy_cnt_q <= 12'h7d0)
      else $error("temperature busy too long");
   a_sample_one: assert property (o_sample |=> !o_sample)
      else $error("sample pulse longer than one cycle");
   a_pd_seen: assert property (!i_power_down_reset_n [*4] |-> o_hw_power_down)
      else $error("power-down not reported");
   a_pd_clears: assert property (o_hw_power_down [*2] |-> !o_mux_valid)
      else $error("selection kept in power-down");
   a_mux_nine: assert property (o_mux_valid |-> o_mux_sel <= 4'h8)
      else $error("source select out of range");
   a_buf_hold: assert property (
      o_buf_valid && !i_buf_ready && !o_hw_power_down |=> o_buf_valid && $stable(o_buf_word))
      else $error("buffered word changed while stalled");
endmodule
bind acs_port acs_port_monitor u_mon (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
   .i_power_down_reset_n(i_power_down_reset_n), .i_cs_n(i_cs_n),
   .o_serial_out_line(o_serial_out_line), .o_serial_out_oe(o_serial_out_oe),
   .o_temp_conv_busy(o_temp_conv_busy), .o_hw_power_down(o_hw_power_down),
   .o_mux_sel(o_mux_sel), .o_mux_valid(o_mux_valid), .o_sample(o_sample),
   .o_buf_valid(o_buf_valid), .i_buf_ready(i_buf_ready), .o_buf_word(o_buf_word));

// File: dv/tb.sv
// Self-checking bench for the converter serial port and sequencer.
`timescale 1ns/10ps
module tb;
   logic        clk = 1'b0, rstn = 1'b0, pdn = 1'b1, rdy = 1'b0;
   logic        cs_n, sclk, din, line, oe, busy, hwpd, stby, mval, smp, bval, binr;
   logic [11:0] res = 12'h0;
   logic [3:0]  msel, ch;
   logic [7:0]  mask;
   logic [15:0] bword, rd, prev;
   logic [15:0] exq[$];
   logic        track = 1'b0;
   int          n_mismatch = 0, total_checks = 0, k;
   initial forever #25 clk = ~clk;
   acs_host_model host (.i_clk_sys(clk), .i_line(line), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_din(din));
   acs_port dut (.i_clk_sys(clk), .i_resetn(rstn), .i_power_down_reset_n(pdn),
      .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_serial_out_line(line),
      .o_serial_out_oe(oe), .o_temp_conv_busy(busy), .o_hw_power_down(hwpd),
      .o_standby(stby), .o_mux_sel(msel), .o_mux_valid(mval), .o_sample(smp),
      .i_conv_result(res), .o_buf_valid(bval), .i_buf_ready(rdy), .o_buf_word(bword),
      .o_buf_in_ready(binr));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic print_verdict;
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [3:0] nxt(input logic [3:0] c, input logic [7:0] m);
      logic [3:0] q;
      q = c;
      do q = (q == 4'h7) ? 4'h0 : q + 4'h1; while (!m[q[2:0]]);
      return q;
   endfunction
   task automatic xfer(input logic [15:0] w, input int n);
      logic [11:0] v;
      v = 12'($urandom);
      @(posedge clk) res <= v;
      // The note goes in before the frame whose result it foretells.
      if (track) exq.push_back({ch, v});
      host.frame(w, n, rd);
   endtask
   always @(posedge clk) if (bval && rdy) begin
      chk(bword, exq.size() ? exq.pop_front() : 16'hxxxx);
   end
   initial begin
      void'($urandom(32'hbc9d));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      xfer(16'h7fff, 16);
      chk(rd, 16'hffff);
      xfer(16'hc0ff, 8);
      xfer(16'h0000, 16);
      chk(rd, 16'hffff);
      mask = 8'($urandom) | 8'h01;
      xfer({8'h80, mask}, 16);
      chk(rd, 16'hffff);
      ch = nxt(4'h7, mask);
      prev = 16'hffff;
      track = 1'b1;
      for (int f = 0; f < 17; f++) begin
         if (f == 16) begin
            chk({15'h0, binr}, 16'h0);
            @(posedge clk) rdy <= 1'b1;
            repeat (40) @(posedge clk);
            chk({15'h0, bval}, 16'h0);
         end
         xfer(16'h0000, 16);
         chk(rd, prev);
         prev = {ch, res};
         ch = nxt(ch, mask);
      end
      track = 1'b0;
      repeat (10) @(posedge clk) pdn <= 1'b0;
      chk({15'h0, hwpd}, 16'h1);
      @(posedge clk) pdn <= 1'b1;
      rdy <= 1'b0;
      repeat (6) @(posedge clk);
      xfer(16'h0000, 16);
      chk(rd, 16'hffff);
      xfer(16'hc000, 16);
      xfer(16'h0000, 16);
      chk({15'h0, busy}, 16'h1);
      k = 0;
      while (busy && k < 2100) begin
         @(posedge clk);
         k++;
      end
      chk({15'h0, busy}, 16'h0);
      xfer(16'h0000, 16);
      chk({12'h0, rd[15:12]}, 16'h8);
      xfer(16'ha001, 16);
      repeat (4) @(posedge clk);
      chk({15'h0, stby}, 16'h1);
      print_verdict();
   end
   initial begin
      #1_000_000;
      n_mismatch++;
      print_verdict();
   end
endmodule
